// [rtl/ssac_cfg.svh]
`ifndef SSAC_CFG_SVH
`define SSAC_CFG_SVH

// Clock period in picoseconds (40 MHz)
`define SSAC_CLK_PS 25000
// Whole conversion time per variant, in nanoseconds
`define SSAC_TCONV8_NS 4000
`define SSAC_TCONV6_NS 3000
`define SSAC_TCONV4_NS 2000
// Each time rounds down, never below one cycle
`define SSAC_CYC(ns) (((ns) * 1000) / `SSAC_CLK_PS)
`define SSAC_CONV8_CYC `SSAC_CYC(`SSAC_TCONV8_NS)
`define SSAC_CONV6_CYC `SSAC_CYC(`SSAC_TCONV6_NS)
`define SSAC_CONV4_CYC `SSAC_CYC(`SSAC_TCONV4_NS)
`define SSAC_CNT_W 8
`define SSAC_DATA_W 16
`define SSAC_MAX_CH 8
`define SSAC_SAR_STEPS 16
`define SSAC_SAR_MSB 15
// Bit counter wraps past bit 0 into this done flag
`define SSAC_SAR_DONE 4
`define SSAC_CH6_N 6
`define SSAC_CH4_N 4

`endif

// [rtl/ssac_pkg.sv]
package ssac_pkg;
   typedef enum logic [1:0] {
      SSAC_VAR_8CH,
      SSAC_VAR_6CH,
      SSAC_VAR_4CH
   } ssac_variant_t;

   typedef enum logic [1:0] {
      SSAC_ST_ACQUIRE,
      SSAC_ST_CONVERT,
      SSAC_ST_COMMIT
   } ssac_state_t;
endpackage : ssac_pkg

// [rtl/ssac_sync.sv]
`timescale 1ns/10ps
// Three-stage pin synchroniser; output changes once stages two and three agree
module ssac_sync (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic pin,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         level <= 1'b0;
      end else if (s2_q == s3_q) begin
         level <= s3_q;
      end
   end
endmodule : ssac_sync

// [rtl/ssac_ctrl.sv]
`timescale 1ns/10ps
`include "ssac_cfg.svh"
module ssac_ctrl
   import ssac_pkg::*;
#(
   parameter ssac_variant_t VARIANT = SSAC_VAR_8CH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic conversion_start_a,
   input wire logic conversion_start_b,
   input wire logic range_sel,
   input wire logic ref_sel,
   input wire logic [`SSAC_MAX_CH-1:0] cmp_in,
   output logic busy,
   output logic [`SSAC_MAX_CH-1:0] hold,
   output logic range_10v,
   output logic int_ref_en,
   output logic [`SSAC_MAX_CH-1:0][`SSAC_DATA_W-1:0] result,
   output logic [`SSAC_MAX_CH-1:0][`SSAC_DATA_W-1:0] sar_trial
);
   localparam int NCH = (VARIANT == SSAC_VAR_8CH) ? `SSAC_MAX_CH :
                        (VARIANT == SSAC_VAR_6CH) ? `SSAC_CH6_N :
                        `SSAC_CH4_N;
   localparam int CONV_CYC = (VARIANT == SSAC_VAR_8CH) ? `SSAC_CONV8_CYC :
                             (VARIANT == SSAC_VAR_6CH) ? `SSAC_CONV6_CYC :
                             `SSAC_CONV4_CYC;
   localparam int CYC = (CONV_CYC < 1) ? 1 : CONV_CYC;
   localparam int HALF = NCH / 2;
   // Spread the SAR bit decisions evenly across the conversion time
   localparam int STEP_CYC = (CYC / `SSAC_SAR_STEPS < 1) ? 1 :
                             CYC / `SSAC_SAR_STEPS;

   logic cs_a;
   logic cs_b;
   logic cs_a_q;
   logic cs_b_q;
   logic rng;
   logic ref_lvl;
   logic rise_a;
   logic rise_b;
   logic seen_a_q;
   logic seen_b_q;
   ssac_state_t state_q;
   logic [`SSAC_CNT_W-1:0] cnt_q;
   logic [`SSAC_CNT_W-1:0] step_q;
   logic [4:0] bit_q;
   logic [`SSAC_MAX_CH-1:0][`SSAC_DATA_W-1:0] sar_q;

   ssac_sync u_sync_a (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin(conversion_start_a),
      .level(cs_a)
   );
   ssac_sync u_sync_b (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin(conversion_start_b),
      .level(cs_b)
   );
   ssac_sync u_sync_r (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin(range_sel),
      .level(rng)
   );
   // Free running, so the select is already known while reset is high
   ssac_sync u_sync_ref (
      .clk_sys(clk_sys),
      .srst(1'b0),
      .pin(ref_sel),
      .level(ref_lvl)
   );

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cs_a_q <= 1'b0;
         cs_b_q <= 1'b0;
      end else begin
         cs_a_q <= cs_a;
         cs_b_q <= cs_b;
      end
   end

   // Edges are dropped outside acquisition
   assign rise_a = cs_a & ~cs_a_q & (state_q == SSAC_ST_ACQUIRE);
   assign rise_b = cs_b & ~cs_b_q & (state_q == SSAC_ST_ACQUIRE);

   // Range applies at once; no settling wait inside, the host owns that
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         range_10v <= 1'b0;
      end else begin
         range_10v <= rng;
      end
   end

   // Taken only while reset is held; select must settle 5 cycles earlier
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         int_ref_en <= ref_lvl;
      end
   end

   // Hold per channel set; released together at busy fall
   generate
      for (genvar i = 0; i < `SSAC_MAX_CH; i++) begin : g_hold
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               hold[i] <= 1'b0;
            end else if (state_q == SSAC_ST_COMMIT) begin
               hold[i] <= 1'b0;
            end else if (i < NCH && i < HALF && rise_a) begin
               hold[i] <= 1'b1;
            end else if (i < NCH && i >= HALF && rise_b) begin
               hold[i] <= 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         seen_a_q <= 1'b0;
         seen_b_q <= 1'b0;
      end else if (state_q != SSAC_ST_ACQUIRE) begin
         seen_a_q <= 1'b0;
         seen_b_q <= 1'b0;
      end else begin
         seen_a_q <= seen_a_q | rise_a;
         seen_b_q <= seen_b_q | rise_b;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= SSAC_ST_ACQUIRE;
         busy <= 1'b0;
         cnt_q <= '0;
      end else begin
         case (state_q)
            SSAC_ST_ACQUIRE: begin
               // Start only once both sets are in hold
               if ((seen_a_q | rise_a) && (seen_b_q | rise_b)) begin
                  state_q <= SSAC_ST_CONVERT;
                  busy <= 1'b1;
                  cnt_q <= '0;
               end
            end
            SSAC_ST_CONVERT: begin
               if (cnt_q == `SSAC_CNT_W'(CYC - 1)) begin
                  state_q <= SSAC_ST_COMMIT;
               end
               cnt_q <= cnt_q + 1'b1;
            end
            SSAC_ST_COMMIT: begin
               state_q <= SSAC_ST_ACQUIRE;
               busy <= 1'b0;
            end
            default: begin
               state_q <= SSAC_ST_ACQUIRE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // Bit sequencer of the successive approximation
   always_ff @(posedge clk_sys) begin
      if (srst || state_q != SSAC_ST_CONVERT) begin
         step_q <= '0;
         bit_q <= 5'(`SSAC_SAR_MSB);
      end else if (step_q == `SSAC_CNT_W'(STEP_CYC - 1)) begin
         step_q <= '0;
         // Spare steps after bit 0 must not decide bit 0 again
         if (!bit_q[`SSAC_SAR_DONE]) begin
            bit_q <= bit_q - 1'b1;
         end
      end else begin
         step_q <= step_q + 1'b1;
      end
   end

   // Twos complement SAR: trial sets each bit below the sign bit, comparator keeps or drops it
   generate
      for (genvar c = 0; c < `SSAC_MAX_CH; c++) begin : g_sar
         always_ff @(posedge clk_sys) begin
            if (srst || state_q == SSAC_ST_ACQUIRE) begin
               // Sign bit trial starts at midscale code 0
               sar_q[c] <= '0;
            end else if (state_q == SSAC_ST_CONVERT &&
                         !bit_q[`SSAC_SAR_DONE] &&
                         step_q == `SSAC_CNT_W'(STEP_CYC - 1)) begin
               if (bit_q == 5'(`SSAC_SAR_MSB)) begin
                  sar_q[c][`SSAC_SAR_MSB] <= ~cmp_in[c];
               end else begin
                  sar_q[c][bit_q[3:0]] <= cmp_in[c];
               end
               // Next lower bit goes in as the trial for the next step
               if (bit_q != 5'h00) begin
                  sar_q[c][bit_q[3:0] - 4'h1] <= 1'b1;
               end
            end
         end
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               sar_trial[c] <= '0;
            end else begin
               sar_trial[c] <= sar_q[c];
            end
         end
         // Previous results stay visible until busy falls
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               result[c] <= '0;
            end else if (state_q == SSAC_ST_COMMIT) begin
               result[c] <= (c < NCH) ? sar_q[c] : '0;
            end
         end
      end
   endgenerate
endmodule : ssac_ctrl

// [bench/ssac_checker.sv]
`timescale 1ns/10ps
`include "ssac_cfg.svh"
module ssac_checker
   import ssac_pkg::*;
#(
   parameter ssac_variant_t VARIANT = SSAC_VAR_8CH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic conversion_start_a,
   input wire logic range_sel,
   input wire logic ref_sel,
   input wire logic busy,
   input wire logic [`SSAC_MAX_CH-1:0] hold,
   input wire logic range_10v,
   input wire logic int_ref_en,
   input wire logic [`SSAC_MAX_CH-1:0][`SSAC_DATA_W-1:0] result
);
   localparam int CYC = VARIANT == SSAC_VAR_8CH ? `SSAC_CONV8_CYC :
      VARIANT == SSAC_VAR_6CH ? `SSAC_CONV6_CYC : `SSAC_CONV4_CYC;
   localparam logic [7:0] MASK = VARIANT == SSAC_VAR_8CH ? 8'hff :
      VARIANT == SSAC_VAR_6CH ? 8'h3f : 8'h0f;
   logic [`SSAC_CNT_W-1:0] busy_cnt_q;
   always_ff @(posedge clk_sys) begin
      if (srst || !busy) busy_cnt_q <= '0;
      else busy_cnt_q <= busy_cnt_q + 1'b1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   busy_len_a: assert property (
      !$past(srst) && $fell(busy) |-> busy_cnt_q == CYC + 1)
      else $error("busy length wrong");
   hold_set_a: assert property (busy |-> hold == MASK)
      else $error("hold incomplete while busy");
   hold_rel_a: assert property ($fell(busy) |-> hold == 8'h00)
      else $error("hold kept after busy");
   result_keep_a: assert property (
      !$past(srst) && !$fell(busy) |-> $stable(result))
      else $error("result changed outside busy fall");
   ref_take_a: assert property (
      $past(srst) |-> int_ref_en == $past(ref_sel, 5))
      else $error("reference mode not taken at reset");
   ref_lock_a: assert property (!$past(srst) |-> $stable(int_ref_en))
      else $error("reference mode moved");
   range_a: assert property (
      $stable(range_sel) [*8] |=> range_10v == $past(range_sel))
      else $error("range not followed");
   start_hold_a: assert property (
      $rose(conversion_start_a) && !busy |-> ##[1:8] hold[0])
      else $error("start edge not held");
   cover property ($rose(busy) && range_10v);
   cover property ($rose(busy) && !range_10v);
   cover property ($fell(busy));
endmodule : ssac_checker
////////////////////////////////////////
bind ssac_ctrl ssac_checker #(.VARIANT(VARIANT)) u_chk (.clk_sys, .srst,
   .conversion_start_a, .range_sel, .ref_sel, .busy, .hold, .range_10v,
   .int_ref_en, .result);

// [bench/ssac_front_model.sv]
`timescale 1ns/10ps
module ssac_front_model (
   input wire logic clk_sys,
   input wire logic range_10v,
   input wire logic [7:0] hold,
   input wire logic [7:0][15:0] sar_trial,
   output logic [7:0] cmp_in
);
   real vin [8] = '{default: 0.0};
   real q;
   logic signed [15:0] held_q [8] = '{default: 16'sh0000};
   // Input sits mid-code, so at or over the trial counts as above
   always_comb
      foreach (cmp_in[i]) cmp_in[i] = held_q[i] >= $signed(sar_trial[i]);
   always @(posedge clk_sys)
      foreach (vin[i]) begin
         q = $floor(vin[i] * 65536.0 / (range_10v ? 20.0 : 10.0) + 0.5);
         q = q > 32767.0 ? 32767.0 : (q < -32768.0 ? -32768.0 : q);
         if (!hold[i]) held_q[i] <= 16'($rtoi(q));
      end
endmodule : ssac_front_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
`include "ssac_cfg.svh"
module tb_top;
   localparam int CYC = `SSAC_CONV8_CYC;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic conversion_start_a = 1'b0;
   logic conversion_start_b = 1'b0;
   logic range_sel = 1'b1;
   logic ref_sel = 1'b1;
   logic busy, range_10v, int_ref_en;
   logic [7:0] cmp_in, hold;
   logic [7:0][15:0] result, sar_trial;
   int mismatches = 0;
   int compares = 0;
   real v_in [8] = '{2.5, -2.5, 5.0, -10.0, 0.0, 10.0, 1.25, -5.0};
   logic [15:0] e10 [8] = '{16'h2000, 16'he000, 16'h4000, 16'h8000,
      16'h0000, 16'h7fff, 16'h1000, 16'hc000};
   logic [15:0] e5 [8] = '{16'h4000, 16'hc000, 16'h7fff, 16'h8000,
      16'h0000, 16'h7fff, 16'h2000, 16'h8000};
   logic [15:0] prev [8] = '{default: 16'h0000};
   ssac_ctrl #(.VARIANT(ssac_pkg::SSAC_VAR_8CH)) i_dut (.clk_sys, .srst,
      .conversion_start_a, .conversion_start_b, .range_sel, .ref_sel,
      .cmp_in, .busy, .hold, .range_10v, .int_ref_en, .result, .sar_trial);
   ssac_front_model i_front (.clk_sys, .range_10v, .hold, .sar_trial,
      .cmp_in);
   initial forever #12.5 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : cyc
   task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         $display("BAD %s exp %h got %h", what, exp, got);
         mismatches++;
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // Starts pulse again mid-run; inputs jump once sampled
   task automatic run(int gap, logic [15:0] e [8]);
      int n;
      foreach (v_in[i]) i_front.vin[i] = v_in[i];
      conversion_start_a = 1'b1;
      if (gap > 0) begin
         cyc(gap);
         chk("set a only", {7'h00, busy, hold}, 16'h000f);
      end
      conversion_start_b = 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      foreach (v_in[i]) i_front.vin[i] = -9.0;
      n = 0;
      while (busy === 1'b1 && n < 400) begin
         if (n == 30) chk("old result", result[6], prev[6]);
         conversion_start_a = n < 40 || n > 50;
         conversion_start_b = n < 40 || n > 50;
         cyc(1);
         n++;
      end
      chk("busy length", 16'(n), 16'(CYC + 1));
      chk("hold", {8'h00, hold}, 16'h0000);
      foreach (e[i]) chk("result", result[i], e[i]);
      prev = e;
      conversion_start_a = 1'b0;
      conversion_start_b = 1'b0;
      cyc(10);
      chk("no restart", {15'h0000, busy}, 16'h0000);
   endtask : run
   task automatic sc_ref();
      ref_sel = 1'b0;
      cyc(4);
      chk("ref held", {15'h0000, int_ref_en}, 16'h0001);
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      cyc(4);
      chk("external ref", {15'h0000, int_ref_en}, 16'h0000);
   endtask : sc_ref
   initial begin
      cyc(16);
      srst = 1'b0;
      cyc(4);
      chk("internal ref", {15'h0000, int_ref_en}, 16'h0001);
      run(0, e10);
      run(12, e10);
      range_sel = 1'b0;
      cyc(3200);
      chk("range", {15'h0000, range_10v}, 16'h0000);
      run(0, e5);
      sc_ref();
      tally_and_finish();
   end
   initial begin
      #500us;
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_top
